// ===== src/vcd_regs.vh
// constants for the carrier address decoder and interrupt router
`ifndef VCD_REGS_VH
`define VCD_REGS_VH
`define VCD_AM_SIO_NP 6'h29
`define VCD_AM_SIO_SUP 6'h2D
`define VCD_AM_A24_0 6'h39
`define VCD_AM_A24_1 6'h3A
`define VCD_AM_A24_2 6'h3D
`define VCD_AM_A24_3 6'h3E
`define VCD_AM_A32_0 6'h09
`define VCD_AM_A32_1 6'h0A
`define VCD_AM_A32_2 6'h0D
`define VCD_AM_A32_3 6'h0E
`define VCD_MEM_OFF 4'h0
`define VCD_MEM_A32 4'hF
`define VCD_SIO_ID_OFF 8'h80
`define VCD_SIO_REG_OFF 8'hC0
`define VCD_IRQ_CFG_OFF 6'h01
`define VCD_MAP_DEFAULT 4'h1
`define VCD_SIO_BASE_DEFAULT 16'h6000
`define VCD_MEM_BASE_DEFAULT 8'hD0
`endif

// ===== src/vcd_decode.v
// vme slave address decoder and interrupt router for a four slot module carrier
`include "vcd_regs.vh"
module vcd_decode #(
    parameter SLOTS = 4
) (
    input wire clk_sys,
    input wire arst_n,
    input wire [3:0] short_io_base_high_switch,
    input wire [1:0] short_io_base_low_switch,
    input wire [3:0] interrupt_map_switch,
    input wire [3:0] memory_size_switch,
    input wire [3:0] memory_base_high_switch,
    input wire [3:0] memory_base_low_switch,
    input wire cyc_valid,
    input wire [31:0] vme_addr,
    input wire [5:0] vme_am,
    input wire lword_n,
    input wire cyc_write,
    input wire [7:0] cyc_wdata,
    input wire [SLOTS-1:0] module_irq_line_zero,
    input wire [SLOTS-1:0] module_irq_line_one,
    output reg hit,
    output reg [SLOTS-1:0] slot_sel,
    output reg io_sel,
    output reg id_sel,
    output reg mem_sel,
    output reg reg_sel,
    output reg [22:0] mem_offset,
    output reg [7:0] reg_rdata,
    output reg [7:1] irq_req_n
);
    // level tables for the eight requests, index slot*2+line
    function [2:0] preset_level;
        input [2:0] pos;
        input [2:0] idx;
        begin
            preset_level = 3'd0;
            case (pos)
                3'd1: begin
                    case (idx)
                        3'd0: preset_level = 3'd1;
                        3'd1: preset_level = 3'd2;
                        3'd2: preset_level = 3'd3;
                        3'd3: preset_level = 3'd4;
                        3'd4: preset_level = 3'd5;
                        3'd5: preset_level = 3'd6;
                        3'd6: preset_level = 3'd7;
                        default: preset_level = 3'd0;
                    endcase
                end
                3'd2: begin
                    case (idx)
                        3'd0: preset_level = 3'd4;
                        3'd1: preset_level = 3'd5;
                        3'd2: preset_level = 3'd2;
                        3'd3: preset_level = 3'd1;
                        3'd4: preset_level = 3'd4;
                        3'd5: preset_level = 3'd5;
                        3'd6: preset_level = 3'd2;
                        default: preset_level = 3'd1;
                    endcase
                end
                3'd3: begin
                    case (idx)
                        3'd0: preset_level = 3'd6;
                        3'd1: preset_level = 3'd4;
                        3'd2: preset_level = 3'd3;
                        3'd3: preset_level = 3'd1;
                        3'd4: preset_level = 3'd6;
                        3'd5: preset_level = 3'd4;
                        3'd6: preset_level = 3'd3;
                        default: preset_level = 3'd1;
                    endcase
                end
                3'd4: begin
                    case (idx)
                        3'd0: preset_level = 3'd1;
                        3'd1: preset_level = 3'd1;
                        3'd2: preset_level = 3'd2;
                        3'd3: preset_level = 3'd2;
                        3'd4: preset_level = 3'd3;
                        3'd5: preset_level = 3'd3;
                        3'd6: preset_level = 3'd4;
                        default: preset_level = 3'd4;
                    endcase
                end
                default: begin
                    preset_level = 3'd0;
                end
            endcase
        end
    endfunction

    wire regs_on = ~interrupt_map_switch[3];
    wire [2:0] map_pos = interrupt_map_switch[2:0];

    // per request programmed levels; reset clears them, the first clock after reset loads the switch preset, a switch change reloads
    reg [2:0] level [0:2*SLOTS-1];
    reg [3:0] map_seen;
    reg seeded;

    // short io decode
    wire [5:0] sio_base = {short_io_base_high_switch, short_io_base_low_switch};
    wire sio_am = (vme_am == `VCD_AM_SIO_NP) || (vme_am == `VCD_AM_SIO_SUP);
    wire sio_hit = sio_am && lword_n && (vme_addr[15:10] == sio_base);
    wire [1:0] sio_slot = vme_addr[9:8];
    wire [7:0] sio_off = vme_addr[7:0];
    wire sio_io = ~sio_off[7];
    wire sio_reg = regs_on && (sio_off >= `VCD_SIO_REG_OFF);
    wire sio_id = sio_off[7] && !sio_reg;

    // memory decode
    wire mem_a24 = (memory_size_switch != `VCD_MEM_OFF) && !memory_size_switch[3];
    wire mem_a32 = (memory_size_switch == `VCD_MEM_A32);
    wire [7:0] mem_base = {memory_base_high_switch, memory_base_low_switch};
    wire a24_am = (vme_am == `VCD_AM_A24_0) || (vme_am == `VCD_AM_A24_1) ||
        (vme_am == `VCD_AM_A24_2) || (vme_am == `VCD_AM_A24_3);
    wire a32_am = (vme_am == `VCD_AM_A32_0) || (vme_am == `VCD_AM_A32_1) ||
        (vme_am == `VCD_AM_A32_2) || (vme_am == `VCD_AM_A32_3);
    // window, slot and offset masks per size; a table keeps variable shifters out of the compare path
    reg [23:0] a24_win_mask;
    reg [1:0] a24_slot;
    reg [22:0] a24_off_mask;
    always @* begin
        a24_win_mask = 24'hFE_0000;
        a24_slot = vme_addr[16:15];
        a24_off_mask = 23'h00_7FFF;
        case (memory_size_switch[2:0])
            3'd1: begin
                a24_win_mask = 24'hFE_0000;
                a24_slot = vme_addr[16:15];
                a24_off_mask = 23'h00_7FFF;
            end
            3'd2: begin
                a24_win_mask = 24'hFC_0000;
                a24_slot = vme_addr[17:16];
                a24_off_mask = 23'h00_FFFF;
            end
            3'd3: begin
                a24_win_mask = 24'hF8_0000;
                a24_slot = vme_addr[18:17];
                a24_off_mask = 23'h01_FFFF;
            end
            3'd4: begin
                a24_win_mask = 24'hF0_0000;
                a24_slot = vme_addr[19:18];
                a24_off_mask = 23'h03_FFFF;
            end
            3'd5: begin
                a24_win_mask = 24'hE0_0000;
                a24_slot = vme_addr[20:19];
                a24_off_mask = 23'h07_FFFF;
            end
            3'd6: begin
                a24_win_mask = 24'hC0_0000;
                a24_slot = vme_addr[21:20];
                a24_off_mask = 23'h0F_FFFF;
            end
            3'd7: begin
                a24_win_mask = 24'h80_0000;
                a24_slot = vme_addr[22:21];
                a24_off_mask = 23'h1F_FFFF;
            end
            default: begin
                a24_win_mask = 24'hFF_FFFF;
                a24_slot = 2'd0;
                a24_off_mask = 23'h00_0000;
            end
        endcase
    end
    // base bits below the window are ignored, so a misaligned base still decodes
    wire [23:0] a24_base = {mem_base, 16'h0000};
    wire a24_match = ((vme_addr[23:0] ^ a24_base) & a24_win_mask) == 24'h00_0000;
    wire mem_hit24 = mem_a24 && a24_am && a24_match && lword_n;
    wire mem_hit32 = mem_a32 && a32_am && lword_n &&
        (vme_addr[31:25] == mem_base[7:1]);
    wire [1:0] mem_slot = mem_hit32 ? vme_addr[24:23] : a24_slot;
    wire [22:0] off_mask = mem_hit32 ? 23'h7F_FFFF : a24_off_mask;
    wire [22:0] next_mem_offset = vme_addr[22:0] & off_mask;
    wire sio_take = cyc_valid && sio_hit;
    wire mem_take = cyc_valid && !sio_hit && (mem_hit24 || mem_hit32);

    // register access: irq config at slot offset 0xC1; level bytes pack two requests
    wire reg_cfg = sio_hit && sio_reg && (sio_off[5:0] == `VCD_IRQ_CFG_OFF);
    wire [2:0] cfg_i0 = {sio_slot, 1'b0};
    wire [2:0] cfg_i1 = {sio_slot, 1'b1};

    // level to request merge; vme lines are active low, wired-or at the backplane
    reg [7:1] next_irq;
    integer k;
    always @* begin
        next_irq = 7'h00;
        for (k = 0; k < 2*SLOTS; k = k + 1) begin
            if (level[k] != 3'd0) begin
                if ((k[0] ? module_irq_line_one[k/2] : module_irq_line_zero[k/2])) begin
                    next_irq[level[k]] = 1'b1;
                end
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2*SLOTS; g = g + 1) begin : g_lvl
            localparam integer IDX_I = g;
            localparam [2:0] IDX = IDX_I[2:0];
            always @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) begin
                    level[g] <= 3'd0;
                end else if (!seeded || (map_seen != interrupt_map_switch)) begin
                    level[g] <= preset_level(map_pos, IDX);
                end else if (cyc_valid && cyc_write && reg_cfg && regs_on) begin
                    if (IDX == cfg_i0) begin
                        level[g] <= cyc_wdata[2:0];
                    end else if (IDX == cfg_i1) begin
                        level[g] <= cyc_wdata[6:4];
                    end
                end
            end
        end
    endgenerate

    // switch tracking: a changed map position reloads the preset levels
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            seeded <= 1'b0;
            map_seen <= `VCD_MAP_DEFAULT;
        end else begin
            seeded <= 1'b1;
            map_seen <= interrupt_map_switch;
        end
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq_req_n <= 7'h7F;
        end else begin
            irq_req_n <= ~next_irq;
        end
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            hit <= 1'b0;
        end else begin
            hit <= cyc_valid && (sio_hit || mem_hit24 || mem_hit32);
        end
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            slot_sel <= {SLOTS{1'b0}};
        end else begin
            slot_sel <= {SLOTS{1'b0}};
            if (sio_take) begin
                slot_sel[sio_slot] <= 1'b1;
            end else if (mem_take) begin
                slot_sel[mem_slot] <= 1'b1;
            end
        end
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            io_sel <= 1'b0;
        end else begin
            io_sel <= sio_take && sio_io;
        end
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            id_sel <= 1'b0;
        end else begin
            id_sel <= sio_take && sio_id;
        end
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reg_sel <= 1'b0;
        end else begin
            reg_sel <= sio_take && sio_reg;
        end
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mem_sel <= 1'b0;
        end else begin
            mem_sel <= mem_take;
        end
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mem_offset <= 23'h00_0000;
        end else begin
            mem_offset <= mem_take ? next_mem_offset : 23'h00_0000;
        end
    end

    // only the irq config byte reads back; other register offsets read zero
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= (sio_take && reg_cfg && !cyc_write) ? {1'b0, level[cfg_i1], 1'b0, level[cfg_i0]} : 8'h00;
        end
    end
endmodule // vcd_decode

// ===== dv/vcd_decode_props.sv
// port checker for the carrier decoder
module vcd_decode_props #(parameter SLOTS = 4) (
    input wire clk_sys,
    input wire arst_n,
    input wire [3:0] short_io_base_high_switch,
    input wire [1:0] short_io_base_low_switch,
    input wire [3:0] interrupt_map_switch,
    input wire [3:0] memory_size_switch,
    input wire cyc_valid,
    input wire [31:0] vme_addr,
    input wire lword_n,
    input wire hit,
    input wire [SLOTS-1:0] slot_sel,
    input wire io_sel,
    input wire id_sel,
    input wire mem_sel,
    input wire reg_sel,
    input wire [7:1] irq_req_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    hit_cause_a: assert property (hit |-> $past(cyc_valid)) else $error("hit without cycle");
    one_space_a: assert property (hit |-> $onehot({io_sel, id_sel, mem_sel, reg_sel}) && $onehot(slot_sel))
        else $error("select not one-hot");
    sio_base_a: assert property (hit && !mem_sel |-> slot_sel == 4'h1 << $past(vme_addr[9:8]) &&
        $past(vme_addr[15:10]) == $past({short_io_base_high_switch, short_io_base_low_switch})) else $error("sio base");
    io_low_a: assert property (io_sel |-> !$past(vme_addr[7])) else $error("io offset");
    reg_win_a: assert property (reg_sel |-> $past(vme_addr[7:6]) == 2'h3 && !$past(interrupt_map_switch[3]))
        else $error("register window");
    mem_on_a: assert property (mem_sel |-> $past(memory_size_switch) inside {[1:7], 15})
        else $error("memory disabled");
    lword_ref_a: assert property (cyc_valid && !lword_n |=> !hit) else $error("long word taken");
    irq_none_a: assert property (interrupt_map_switch == 4'h8 [*3] |-> irq_req_n == 7'h7F)
        else $error("irq in map 8");
    cover property (hit && reg_sel);
    cover property (hit && mem_sel);
    cover property (irq_req_n != 7'h7F);
endmodule // vcd_decode_props

bind vcd_decode vcd_decode_props #(.SLOTS(SLOTS)) vcd_decode_props_inst (.*);

// ===== dv/vcd_master.sv
// vme master model presenting one decoded cycle at a time
module vcd_master (
    input wire clk_sys,
    output logic cyc_valid = 1'b0,
    output logic [31:0] vme_addr = 32'h0000_0000,
    output logic [5:0] vme_am = 6'h00,
    output logic lword_n = 1'b1,
    output logic cyc_write = 1'b0,
    output logic [7:0] cyc_wdata = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic acc(input logic [31:0] a, input logic [5:0] am, input logic lw, input logic we, input logic [7:0] d);
        @(posedge clk_sys);
        cyc_valid <= 1'b1;
        vme_addr <= a;
        vme_am <= am;
        lword_n <= lw;
        cyc_write <= we;
        cyc_wdata <= d;
        @(posedge clk_sys);
        cyc_valid <= 1'b0;
        // released bus must not keep a stale address
        vme_addr <= ~a;
        cyc_wdata <= ~d;
    endtask
endmodule // vcd_master

// ===== dv/vcd_decode_tb.sv
// self-checking bench for the carrier decoder
module vcd_decode_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] sio_hi = 4'h6, map_sw = 4'h1, size_sw = 4'h0, mb_hi = 4'hD, mb_lo = 4'h0, irq0 = 4'h0, irq1 = 4'h0;
    logic [1:0] sio_lo = 2'h0;
    wire cyc_valid, lword_n, cyc_write, hit, io_sel, id_sel, mem_sel, reg_sel;
    wire [31:0] vme_addr;
    wire [5:0] vme_am;
    wire [7:0] cyc_wdata, reg_rdata;
    wire [3:0] slot_sel;
    wire [22:0] mem_offset;
    wire [7:1] irq_req_n;
    int errors = 0;
    int checked = 0;
    always #4 clk_sys = ~clk_sys;
    vcd_master vcd_master_inst (.clk_sys(clk_sys), .cyc_valid(cyc_valid), .vme_addr(vme_addr), .vme_am(vme_am),
        .lword_n(lword_n), .cyc_write(cyc_write), .cyc_wdata(cyc_wdata));
    vcd_decode vcd_decode_inst (.clk_sys(clk_sys), .arst_n(arst_n), .short_io_base_high_switch(sio_hi),
        .short_io_base_low_switch(sio_lo), .interrupt_map_switch(map_sw), .memory_size_switch(size_sw),
        .memory_base_high_switch(mb_hi), .memory_base_low_switch(mb_lo), .cyc_valid(cyc_valid), .vme_addr(vme_addr),
        .vme_am(vme_am), .lword_n(lword_n), .cyc_write(cyc_write), .cyc_wdata(cyc_wdata), .module_irq_line_zero(irq0),
        .module_irq_line_one(irq1), .hit(hit), .slot_sel(slot_sel), .io_sel(io_sel), .id_sel(id_sel),
        .mem_sel(mem_sel), .reg_sel(reg_sel), .mem_offset(mem_offset), .reg_rdata(reg_rdata), .irq_req_n(irq_req_n));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim;
        if (errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    function automatic logic [8:0] e(int s, logic [3:0] k);
        return {1'b1, 4'h1 << s, k};
    endfunction
    // expectation is {hit, slot one-hot, io, id, mem, reg}; selects only judged on a hit
    task automatic go(input logic [31:0] a, input logic [5:0] am, input logic [8:0] x);
        vcd_master_inst.acc(a, am, 1'b1, 1'b0, 8'h00);
        #1;
        chk("hit", hit, x[8]);
        if (x[8]) chk("sel", {hit, slot_sel, io_sel, id_sel, mem_sel, reg_sel}, x);
    endtask
    task automatic t_sio;
        for (int s = 0; s < 4; s++) begin
            go(32'h607F + s * 256, 6'h29, e(s, 4'h8));
            go(32'h6080 + s * 256, 6'h2D, e(s, 4'h4));
            go(32'h60FF + s * 256, 6'h29, e(s, 4'h1));
        end
        go(32'h6400, 6'h29, 9'h000);
        go(32'h6000, 6'h3D, 9'h000);
        vcd_master_inst.acc(32'h6000, 6'h29, 1'b0, 1'b0, 8'h00);
        #1;
        chk("lword", hit, 1'b0);
        @(posedge clk_sys);
        sio_hi <= 4'hA;
        sio_lo <= 2'h3;
        map_sw <= 4'h9;
        go(32'h6000, 6'h29, 9'h000);
        go(32'hAF00, 6'h29, e(3, 4'h8));
        go(32'hAFC1, 6'h2D, e(3, 4'h4));
        // later scenarios address the default short io base
        @(posedge clk_sys);
        sio_hi <= 4'h6;
        sio_lo <= 2'h0;
    endtask
    task automatic t_mem;
        logic [31:0] sz;
        logic [5:0] am24 [4] = '{6'h39, 6'h3A, 6'h3D, 6'h3E};
        logic [5:0] am32 [4] = '{6'h09, 6'h0A, 6'h0D, 6'h0E};
        // base 0x800000 keeps every A24 size aligned
        @(posedge clk_sys);
        mb_hi <= 4'h8;
        for (int n = 0; n < 9; n++) begin
            @(posedge clk_sys);
            size_sw <= 4'(n);
            sz = 32'h0000_4000 << (n % 8);
            go(32'h0080_0000 + 4 * sz - 2, am24[n % 4], n % 8 == 0 ? 9'h000 : e(3, 4'h2));
            if (n % 8 != 0) chk("offset", mem_offset, sz - 2);
        end
        go(32'h0080_0000, 6'h09, 9'h000);
        @(posedge clk_sys);
        mb_hi <= 4'hD;
        size_sw <= 4'hF;
        for (int k = 0; k < 4; k++) go(32'hD100_0010, am32[k], e(2, 4'h2));
        go(32'hD200_0000, 6'h09, 9'h000);
        go(32'hD100_0010, 6'h39, 9'h000);
        @(posedge clk_sys);
        size_sw <= 4'h1;
        go(32'h00D0_0000, 6'h39, e(0, 4'h2));
        go(32'h00D0_0000, 6'h09, 9'h000);
    endtask
    task automatic t_irq;
        logic [3:0] lv;
        logic [31:0] tbl [8] = '{32'h0, 32'h0765_4321, 32'h1254_1254, 32'h1346_1346, 32'h4433_2211, 32'h0, 32'h0, 32'h0};
        for (int p = 0; p < 16; p++) begin
            for (int i = 0; i < 8; i++) begin
                @(posedge clk_sys);
                map_sw <= 4'(p);
                irq0 <= i % 2 ? 4'h0 : 4'h1 << i / 2;
                irq1 <= i % 2 ? 4'h1 << i / 2 : 4'h0;
                repeat (3) @(posedge clk_sys);
                #1;
                lv = 4'(tbl[p % 8] >> 4 * i);
                chk("irq", irq_req_n, lv[2:0] == 3'h0 ? 7'h7F : 7'(~(7'h01 << (lv[2:0] - 3'h1))));
            end
        end
        @(posedge clk_sys);
        map_sw <= 4'h1;
        irq0 <= 4'h1;
        irq1 <= 4'h1;
        vcd_master_inst.acc(32'h60C1, 6'h29, 1'b1, 1'b1, 8'h57);
        vcd_master_inst.acc(32'h60C1, 6'h29, 1'b1, 1'b0, 8'h00);
        #1;
        chk("rdata", reg_rdata, 8'h57);
        repeat (2) @(posedge clk_sys);
        #1;
        chk("irq", irq_req_n, 7'h2F);
        @(posedge clk_sys);
        map_sw <= 4'h9;
        vcd_master_inst.acc(32'h60C1, 6'h29, 1'b1, 1'b1, 8'h57);
        repeat (2) @(posedge clk_sys);
        #1;
        chk("irq", irq_req_n, 7'h7C);
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        t_sio;
        t_mem;
        t_irq;
        end_sim;
    end
    // the tests need under 2000 cycles, so this only fires on a hang
    initial begin
        #200us;
        errors++;
        end_sim;
    end
endmodule // vcd_decode_tb
